// ==== host_port_pkg.sv ====
package host_port_pkg;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;
  localparam int REG_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 10'h09C;
  localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 10'h09E;
  localparam logic [IDX_W-1:0] IDX_DEF_TAG = 10'h0A0;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0B0;
  // Control one fields
  localparam int B_MULTI_Q = 0;
  localparam int B_TAG_REM = 1;
  localparam int B_TAG_INS = 2;
  // Control two fields
  localparam int B_MEMB_LSB = 0;
  localparam int MEMB_W = 3;
  localparam int B_CEIL = 3;
  localparam int B_TX_SNIFF = 5;
  localparam int B_RX_SNIFF = 6;
  localparam int B_SNIFFER = 7;
  localparam int B_LEARN_DIS = 8;
  localparam int B_RX_EN = 9;
  localparam int B_TX_EN = 10;
  localparam int B_BACKPR = 11;
  localparam int B_NON_DEF_VID = 13;
  localparam int B_VLAN_FILT = 14;
  localparam int MEMB_HOST = 2;
  // Default tag fields
  localparam int VID_LSB = 0;
  localparam int VID_W = 12;
  localparam int B_CFI = 12;
  localparam int PRIO_LSB = 13;
  localparam int PRIO_W = 3;
  // Reset values and writable masks
  localparam logic [REG_W-1:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [REG_W-1:0] CTRL_TWO_RST = 16'h0607;
  localparam logic [REG_W-1:0] DEF_TAG_RST = 16'h0001;
  localparam logic [REG_W-1:0] CTRL_ONE_MASK = 16'h0007;
  localparam logic [REG_W-1:0] CTRL_TWO_MASK = 16'h6FEF;
  localparam logic [REG_W-1:0] DEF_TAG_MASK = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {WR_IDLE, WR_RESP} wr_state_e;
endpackage

// ==== reg_access_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
  import host_port_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
    input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
    output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ==== axil_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module axil_port
  import host_port_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Response valid
  input wire logic bready, // Response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read valid
  input wire logic rready, // Read ready
  reg_access_if.bus ra // Register side
);
  function automatic logic [IDX_W-1:0] word_idx(
    input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  wr_state_e wst_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;

  // The write commits one cycle after both halves are held
  assign awready = !aw_have_q && wst_q == WR_IDLE;
  assign wready = !w_have_q && wst_q == WR_IDLE;
  assign ra.wr_en = aw_have_q && w_have_q && wst_q == WR_IDLE;
  assign ra.wr_idx = word_idx(awaddr_q);
  assign ra.wr_data = wdata_q;
  assign ra.wr_strb = wstrb_q;
  assign bvalid = wst_q == WR_RESP;
  assign bresp = bresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (ra.wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (ra.wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wst_q <= WR_IDLE;
      bresp_q <= RESP_OKAY;
    end else begin
      case (wst_q)
        WR_IDLE: begin
          if (ra.wr_en) begin
            wst_q <= WR_RESP;
            bresp_q <= ra.wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wst_q <= WR_IDLE;
          end
        end
        default: wst_q <= WR_IDLE;
      endcase
    end
  end

  assign arready = !rvalid_q;
  assign ra.rd_idx = word_idx(araddr);
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= ra.rd_ok ? ra.rd_data : '0;
      rresp_q <= ra.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== egress_edit.sv ====
`timescale 1ns/10ps
`default_nettype none
module egress_edit
  import host_port_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic tag_ins, // Insert enable
  input wire logic tag_rem, // Strip enable
  input wire logic multi_q, // Four queue mode
  input wire logic tx_en, // Transmit enable
  input wire logic sniffer, // Mirror destination
  input wire logic tx_sniff, // Transmit monitor
  input wire logic eg_valid, // Egress packet
  input wire logic eg_tagged, // Arrived tagged
  input wire logic eg_monitored, // Marked monitored
  input wire logic [VID_W-1:0] eg_src_vid, // Ingress port default VID
  input wire logic [1:0] eg_class, // Priority class
  output logic eg_done_q, // Decision valid
  output logic eg_send_q, // Packet goes out
  output logic eg_insert_q, // Add a tag
  output logic eg_strip_q, // Remove the tag
  output logic [VID_W-1:0] eg_tag_vid_q, // VID to insert
  output logic [1:0] eg_queue_q, // Output queue
  output logic eg_copy_q // Copy to mirror port
);
  logic pass;
  // Monitored copies only leave here when this port is the sniffer
  assign pass = tx_en && (!eg_monitored || sniffer);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eg_done_q <= 1'b0;
      eg_send_q <= 1'b0;
      eg_insert_q <= 1'b0;
      eg_strip_q <= 1'b0;
      eg_tag_vid_q <= '0;
      eg_queue_q <= '0;
      eg_copy_q <= 1'b0;
    end else begin
      eg_done_q <= eg_valid;
      eg_send_q <= eg_valid && pass;
      eg_insert_q <= eg_valid && tag_ins && !eg_tagged;
      eg_strip_q <= eg_valid && tag_rem && eg_tagged;
      eg_tag_vid_q <= eg_src_vid;
      eg_queue_q <= multi_q ? eg_class : 2'h0;
      eg_copy_q <= eg_valid && tx_sniff && tx_en;
    end
  end

  property p_ins;
    @(posedge core_clk) disable iff (rst)
    eg_valid && tag_ins && !eg_tagged |=> eg_insert_q;
  endproperty
  a_ins: assert property (p_ins) else $error("tag not inserted");
  property p_keep;
    @(posedge core_clk) disable iff (rst)
    eg_valid && eg_tagged |=> !eg_insert_q ##0 eg_tag_vid_q == $past(eg_src_vid);
  endproperty
  a_keep: assert property (p_keep) else $error("tagged packet altered");
  property p_strip;
    @(posedge core_clk) disable iff (rst)
    eg_strip_q |-> $past(tag_rem) && $past(eg_tagged);
  endproperty
  a_strip: assert property (p_strip) else $error("bad tag removal");
  property p_queue;
    @(posedge core_clk) disable iff (rst)
    !multi_q |=> eg_queue_q == 2'h0;
  endproperty
  a_queue: assert property (p_queue) else $error("queue in single mode");
  property p_txblock;
    @(posedge core_clk) disable iff (rst)
    !tx_en |=> !eg_send_q && !eg_copy_q;
  endproperty
  a_txblock: assert property (p_txblock) else $error("sent while blocked");
endmodule
`default_nettype wire

// ==== host_port_control.sv ====
// Overview of operation
// - Control-one bit 2 adds a tag to untagged packets leaving the host port.
// - Already tagged packets stay as is; inserted tag uses ingress port VID.
// - Control-one bit 1 strips tags from tagged packets leaving the host port.
// - Control-one bit 0 selects four output queues; clear means one queue.
// - Bit 14 drops packets whose VLAN membership excludes the host port.
// - Bit 13 drops packets whose VID differs from the port default VID.
// - Bit 11 enables half-duplex back pressure; resets to zero.
// - Bit 10 enables transmission on the host port; resets to one.
// - Bit 9 enables reception on the host port; resets to one.
// - Bit 8 set disables source address learning; clear allows learning.
// - Bit 7 makes the host port the mirror destination for monitored packets.
// - Bit 6 mirrors every received packet that is not dropped to the mirror destination.
// - Bit 5 mirrors every transmitted packet to the mirror destination.
// - Bit 3 caps packet priority at the default tag user priority.
// - Bits 2:0 are port membership, host/port2/port1, resetting to 111.
// - Host port traffic goes only to member ports.
// - Default tag holds priority 15:13, CFI 12, VID 11:0; VID resets 1.
`timescale 1ns/10ps
`default_nettype none
module host_port_control
  import host_port_pkg::*;
#(
  parameter int PORTS = 3 // Switch ports incl. host port
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic [ADDR_W-1:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI response valid
  input wire logic bready, // AXI response ready
  input wire logic [ADDR_W-1:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read valid
  input wire logic rready, // AXI read ready
  input wire logic in_valid, // Ingress packet header strobe
  input wire logic in_tagged, // Packet carries a tag
  input wire logic [VID_W-1:0] in_vid, // Tag VID
  input wire logic [PRIO_W-1:0] in_prio, // Tag priority
  input wire logic [PORTS-1:0] in_vlan_memb, // VLAN table membership
  output logic in_done_q, // Ingress decision valid
  output logic in_drop_q, // Discard packet
  output logic in_learn_q, // Learn source address
  output logic in_copy_q, // Copy to mirror port
  output logic [PORTS-2:0] in_fwd_mask_q, // Allowed destinations
  output logic [VID_W-1:0] in_vid_q, // Classified VID
  output logic [PRIO_W-1:0] in_prio_q, // Priority after ceiling
  input wire logic eg_valid, // Egress packet strobe
  input wire logic eg_tagged, // Arrived tagged
  input wire logic eg_monitored, // Marked monitored
  input wire logic [VID_W-1:0] eg_src_vid, // Ingress port default VID
  input wire logic [1:0] eg_class, // Priority class
  output logic eg_done_q, // Egress decision valid
  output logic eg_send_q, // Packet goes out
  output logic eg_insert_q, // Add a tag
  output logic eg_strip_q, // Remove the tag
  output logic [VID_W-1:0] eg_tag_vid_q, // VID to insert
  output logic [1:0] eg_queue_q, // Output queue
  output logic eg_copy_q, // Copy to mirror port
  output logic back_pressure_q, // Half-duplex back pressure
  output logic port_rx_en_q, // Reception enabled
  output logic port_tx_en_q // Transmission enabled
);
  reg_access_if ra ();

  logic [REG_W-1:0] ctrl_one_q, ctrl_two_q, def_tag_q;
  logic [REG_W-1:0] drop_cnt_q;
  logic [VID_W-1:0] port_default_vlan_id;
  logic [PRIO_W-1:0] ceil_prio, eff_prio;
  logic [VID_W-1:0] eff_vid;
  logic drop;

  if (PORTS != MEMB_W) begin
    $error("PORTS must match the membership field width");
  end

  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] nv;
    nv = old;
    if (strb[0]) begin
      nv[7:0] = data[7:0];
    end
    if (strb[1]) begin
      nv[15:8] = data[15:8];
    end
    return nv & mask;
  endfunction

  // One decode for every write target keeps strobe and answer consistent
  function automatic logic wr_hit(input logic en,
    input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] target);
    return en && idx == target;
  endfunction

  axil_port u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .ra(ra)
  );

  // Status is read-only; writing it answers with an error
  assign ra.wr_ok = wr_hit(1'b1, ra.wr_idx, IDX_CTRL_ONE) ||
    wr_hit(1'b1, ra.wr_idx, IDX_CTRL_TWO) ||
    wr_hit(1'b1, ra.wr_idx, IDX_DEF_TAG);

  always_comb begin
    ra.rd_ok = 1'b1;
    ra.rd_data = '0;
    case (ra.rd_idx)
      IDX_CTRL_ONE: ra.rd_data[REG_W-1:0] = ctrl_one_q;
      IDX_CTRL_TWO: ra.rd_data[REG_W-1:0] = ctrl_two_q;
      IDX_DEF_TAG: ra.rd_data[REG_W-1:0] = def_tag_q;
      IDX_STATUS: ra.rd_data[REG_W-1:0] = drop_cnt_q;
      default: ra.rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_one_q <= CTRL_ONE_RST;
    end else if (wr_hit(ra.wr_en, ra.wr_idx, IDX_CTRL_ONE)) begin
      ctrl_one_q <= merge(ctrl_one_q, ra.wr_data, ra.wr_strb,
        CTRL_ONE_MASK);
    end
  end

  // Reserved bits are masked off so they always read back as zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_two_q <= CTRL_TWO_RST;
    end else if (wr_hit(ra.wr_en, ra.wr_idx, IDX_CTRL_TWO)) begin
      ctrl_two_q <= merge(ctrl_two_q, ra.wr_data, ra.wr_strb,
        CTRL_TWO_MASK);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      def_tag_q <= DEF_TAG_RST;
    end else if (wr_hit(ra.wr_en, ra.wr_idx, IDX_DEF_TAG)) begin
      def_tag_q <= merge(def_tag_q, ra.wr_data, ra.wr_strb,
        DEF_TAG_MASK);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      back_pressure_q <= 1'b0;
      port_rx_en_q <= 1'b1;
      port_tx_en_q <= 1'b1;
    end else begin
      back_pressure_q <= ctrl_two_q[B_BACKPR];
      port_rx_en_q <= ctrl_two_q[B_RX_EN];
      port_tx_en_q <= ctrl_two_q[B_TX_EN];
    end
  end

  assign port_default_vlan_id = def_tag_q[VID_LSB +: VID_W];
  assign ceil_prio = def_tag_q[PRIO_LSB +: PRIO_W];
  // A null VID takes the port default VID, as an untagged packet does
  assign eff_vid = (in_tagged && in_vid != '0) ? in_vid : port_default_vlan_id;
  assign eff_prio = in_tagged ? in_prio : ceil_prio;

  assign drop = !ctrl_two_q[B_RX_EN] ||
    (ctrl_two_q[B_VLAN_FILT] && !in_vlan_memb[MEMB_HOST]) ||
    (ctrl_two_q[B_NON_DEF_VID] && eff_vid != port_default_vlan_id);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_done_q <= 1'b0;
      in_drop_q <= 1'b0;
      in_learn_q <= 1'b0;
      in_copy_q <= 1'b0;
      in_fwd_mask_q <= '0;
      in_vid_q <= '0;
      in_prio_q <= '0;
    end else begin
      in_done_q <= in_valid;
      in_drop_q <= in_valid && drop;
      in_learn_q <= in_valid && !drop && !ctrl_two_q[B_LEARN_DIS];
      in_copy_q <= in_valid && !drop && ctrl_two_q[B_RX_SNIFF];
      in_fwd_mask_q <= (in_valid && !drop) ?
        ctrl_two_q[B_MEMB_LSB +: PORTS-1] : '0;
      in_vid_q <= eff_vid;
      in_prio_q <= (ctrl_two_q[B_CEIL] && eff_prio > ceil_prio) ?
        ceil_prio : eff_prio;
    end
  end

  // Counts discards; wraps silently, software reads deltas
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drop_cnt_q <= '0;
    end else if (in_valid && drop) begin
      drop_cnt_q <= drop_cnt_q + 16'h0001;
    end
  end

  egress_edit u_egress (
    .core_clk(core_clk),
    .rst(rst),
    .tag_ins(ctrl_one_q[B_TAG_INS]),
    .tag_rem(ctrl_one_q[B_TAG_REM]),
    .multi_q(ctrl_one_q[B_MULTI_Q]),
    .tx_en(ctrl_two_q[B_TX_EN]),
    .sniffer(ctrl_two_q[B_SNIFFER]),
    .tx_sniff(ctrl_two_q[B_TX_SNIFF]),
    .eg_valid(eg_valid),
    .eg_tagged(eg_tagged),
    .eg_monitored(eg_monitored),
    .eg_src_vid(eg_src_vid),
    .eg_class(eg_class),
    .eg_done_q(eg_done_q),
    .eg_send_q(eg_send_q),
    .eg_insert_q(eg_insert_q),
    .eg_strip_q(eg_strip_q),
    .eg_tag_vid_q(eg_tag_vid_q),
    .eg_queue_q(eg_queue_q),
    .eg_copy_q(eg_copy_q)
  );

  property p_filter;
    @(posedge core_clk) disable iff (rst)
    in_valid && ctrl_two_q[B_VLAN_FILT] && !in_vlan_memb[MEMB_HOST]
      |=> in_drop_q && !in_learn_q;
  endproperty
  a_filter: assert property (p_filter) else $error("filter miss");
  property p_vid_match;
    @(posedge core_clk) disable iff (rst)
    in_valid && ctrl_two_q[B_NON_DEF_VID] && in_tagged && in_vid != '0 &&
      in_vid != port_default_vlan_id |=> in_drop_q;
  endproperty
  a_vid_match: assert property (p_vid_match) else $error("VID kept");
  property p_rxen;
    @(posedge core_clk) disable iff (rst)
    in_drop_q && !$past(ctrl_two_q[B_VLAN_FILT]) &&
      !$past(ctrl_two_q[B_NON_DEF_VID]) |-> !$past(ctrl_two_q[B_RX_EN]);
  endproperty
  a_rxen: assert property (p_rxen) else $error("spurious drop");
  property p_learn;
    @(posedge core_clk) disable iff (rst)
    in_learn_q |-> !$past(ctrl_two_q[B_LEARN_DIS]) && !in_drop_q;
  endproperty
  a_learn: assert property (p_learn) else $error("learned");
  property p_ceil;
    @(posedge core_clk) disable iff (rst)
    in_valid && ctrl_two_q[B_CEIL] |=> in_prio_q <= $past(ceil_prio);
  endproperty
  a_ceil: assert property (p_ceil) else $error("ceiling passed");
  property p_fwd;
    @(posedge core_clk) disable iff (rst)
    (in_fwd_mask_q & ~$past(ctrl_two_q[B_MEMB_LSB +: PORTS-1])) == '0;
  endproperty
  a_fwd: assert property (p_fwd) else $error("non-member fwd");
  property p_bp;
    @(posedge core_clk) disable iff (rst)
    ra.wr_en && ra.wr_idx == IDX_CTRL_TWO && ra.wr_strb[1]
      |=> ##1 back_pressure_q == $past(ra.wr_data[B_BACKPR], 2);
  endproperty
  a_bp: assert property (p_bp) else $error("back pressure lag");
  property p_rsvd;
    @(posedge core_clk) disable iff (rst)
    (ctrl_two_q & ~CTRL_TWO_MASK) == '0 ##0
      (ctrl_one_q & ~CTRL_ONE_MASK) == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  // Decisions follow the registers as sampled on the header edge
  property p_learn_on;
    @(posedge core_clk) disable iff (rst)
    in_valid && !drop && !ctrl_two_q[B_LEARN_DIS] |=> in_learn_q;
  endproperty
  a_learn_on: assert property (p_learn_on) else $error("no learning");
  property p_rxcopy;
    @(posedge core_clk) disable iff (rst)
    in_valid && !drop && ctrl_two_q[B_RX_SNIFF] |=> in_copy_q;
  endproperty
  a_rxcopy: assert property (p_rxcopy) else $error("copy missing");
  property p_nocopy;
    @(posedge core_clk) disable iff (rst)
    !ctrl_two_q[B_RX_SNIFF] |=> !in_copy_q;
  endproperty
  a_nocopy: assert property (p_nocopy) else $error("stray copy");
  property p_memb;
    @(posedge core_clk) disable iff (rst)
    in_valid && !drop |=>
      in_fwd_mask_q == $past(ctrl_two_q[B_MEMB_LSB +: PORTS-1]);
  endproperty
  a_memb: assert property (p_memb) else $error("member lost");

  // Level outputs trail the register by exactly one cycle
  property p_txlvl;
    @(posedge core_clk) disable iff (rst)
    port_tx_en_q == $past(ctrl_two_q[B_TX_EN]);
  endproperty
  a_txlvl: assert property (p_txlvl) else $error("tx level");
  property p_rxlvl;
    @(posedge core_clk) disable iff (rst)
    port_rx_en_q == $past(ctrl_two_q[B_RX_EN]);
  endproperty
  a_rxlvl: assert property (p_rxlvl) else $error("rx level");

  property p_defvid;
    @(posedge core_clk) disable iff (rst)
    in_valid && !in_tagged |=> in_vid_q == $past(port_default_vlan_id);
  endproperty
  a_defvid: assert property (p_defvid) else $error("default VID");
  property p_ceil_off;
    @(posedge core_clk) disable iff (rst)
    in_valid && in_tagged && !ctrl_two_q[B_CEIL] |=> in_prio_q == $past(in_prio);
  endproperty
  a_ceil_off: assert property (p_ceil_off) else $error("prio moved");
  property p_cnt;
    @(posedge core_clk) disable iff (rst)
    in_valid && drop |=> drop_cnt_q == $past(drop_cnt_q) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("drop count");
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import host_port_pkg::*;
  logic core_clk, rst;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, eg_class, eg_queue_q, in_fwd_mask_q;
  logic in_valid, in_tagged, in_done_q, in_drop_q, in_learn_q, in_copy_q;
  logic [11:0] in_vid, in_vid_q, eg_src_vid, eg_tag_vid_q;
  logic [2:0] in_prio, in_vlan_memb, in_prio_q;
  logic eg_valid, eg_tagged, eg_monitored, eg_done_q, eg_send_q;
  logic eg_insert_q, eg_strip_q, eg_copy_q;
  logic back_pressure_q, port_rx_en_q, port_tx_en_q;
  int err_total, n_checks;

  // Every port name matches a bench signal of the same width
  host_port_control host_port_control_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ready is sampled at the falling edge; nothing moves before the next rise
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      rs = bresp;
      @(posedge core_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end while (!b_ok && n < 40);
    bready <= 1'b0;
    if (!b_ok) err_total++;
    // Let register copies launched at the answer edge settle
    #1;
  endtask

  task automatic rdr(input logic [11:0] a);
    int n;
    logic ar_ok, r_ok;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge core_clk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
    end while (!r_ok && n < 40);
    rready <= 1'b0;
    if (!r_ok) err_total++;
  endtask

  task automatic ing(input logic t, input logic [11:0] v,
      input logic [2:0] p, input logic [2:0] m);
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_tagged <= t;
    in_vid <= v;
    in_prio <= p;
    in_vlan_memb <= m;
    @(posedge core_clk);
    in_valid <= 1'b0;
    #1;
  endtask

  task automatic egr(input logic t, input logic mon, input logic [11:0] v,
      input logic [1:0] c);
    @(posedge core_clk);
    eg_valid <= 1'b1;
    eg_tagged <= t;
    eg_monitored <= mon;
    eg_src_vid <= v;
    eg_class <= c;
    @(posedge core_clk);
    eg_valid <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    rdr(12'h278);
    chk(rd, 32'h0000_0607);
    rdr(12'h280);
    chk(rd, 32'h0000_0001);
    chk({back_pressure_q, port_tx_en_q, port_rx_en_q}, 3'b011);
    rdr(12'h3FC);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    wr(12'h278, 16'hFFFF);
    chk(rs, RESP_OKAY);
    rdr(12'h278);
    chk(rd, 32'h0000_6FEF);
  endtask

  task automatic t_egress();
    wr(12'h270, 16'h0007);
    egr(1'b0, 1'b0, 12'h123, 2'h3);
    chk({eg_done_q, eg_send_q, eg_insert_q, eg_strip_q}, 4'hE);
    chk({eg_tag_vid_q, eg_queue_q}, {12'h123, 2'h3});
    egr(1'b1, 1'b0, 12'h456, 2'h1);
    chk({eg_insert_q, eg_strip_q, eg_queue_q}, 4'h5);
    wr(12'h270, 16'h0000);
    egr(1'b1, 1'b0, 12'h456, 2'h2);
    chk({eg_insert_q, eg_strip_q, eg_queue_q}, 4'h0);
  endtask

  task automatic t_ingress();
    wr(12'h280, 16'h4005);
    wr(12'h278, 16'h6609);
    ing(1'b1, 12'h005, 3'h7, 3'h4);
    chk({in_done_q, in_drop_q, in_learn_q, in_fwd_mask_q}, 5'h15);
    chk(in_prio_q, 3'h2);
    ing(1'b1, 12'h005, 3'h1, 3'h4);
    chk(in_prio_q, 3'h1);
    ing(1'b1, 12'h005, 3'h1, 3'h3);
    chk({in_drop_q, in_fwd_mask_q}, 3'h4);
    ing(1'b1, 12'h006, 3'h1, 3'h4);
    chk(in_drop_q, 1'b1);
    ing(1'b0, 12'h000, 3'h0, 3'h4);
    chk({in_drop_q, in_vid_q}, 13'h0005);
  endtask

  task automatic t_mirror();
    wr(12'h278, 16'h07E6);
    ing(1'b1, 12'h009, 3'h0, 3'h0);
    chk({in_drop_q, in_learn_q, in_fwd_mask_q}, 4'h2);
    chk(in_copy_q, 1'b1);
    egr(1'b0, 1'b1, 12'h001, 2'h0);
    chk({eg_send_q, eg_copy_q}, 2'h3);
    wr(12'h278, 16'h0606);
    egr(1'b0, 1'b1, 12'h001, 2'h0);
    chk({eg_send_q, eg_copy_q}, 2'h0);
  endtask

  task automatic t_enables();
    wr(12'h278, 16'h0800);
    chk({back_pressure_q, port_tx_en_q, port_rx_en_q}, 3'h4);
    ing(1'b1, 12'h009, 3'h0, 3'h4);
    chk(in_drop_q, 1'b1);
    egr(1'b0, 1'b0, 12'h001, 2'h0);
    chk(eg_send_q, 1'b0);
    // One VLAN filter drop and one VID mismatch drop earlier plus the receive-disabled one
    rdr(12'h2C0);
    chk(rd, 32'h0000_0003);
    wr(12'h2C0, 16'h0000);
    chk(rs, RESP_SLVERR);
  endtask

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    {in_valid, in_tagged, in_vid, in_prio, in_vlan_memb} = '0;
    {eg_valid, eg_tagged, eg_monitored, eg_src_vid, eg_class} = '0;
    err_total = 0;
    n_checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_egress();
    t_ingress();
    t_mirror();
    t_enables();
    give_verdict();
  end

  // The whole run needs well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
